// ===== lfc_core.sv
/*
  Function control latch of a 16-channel LED sink driver, with on/off latch,
  status reload and derived controls. Assumes ref_clk is the system clock, shift_clk
  the host's shift clock and osc_clk the internal oscillator; flag inputs are levels.
*/
`timescale 1ns/1ps
`default_nettype none
module lfc_core (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic shift_clk, // Host shift clock
  input wire logic osc_clk, // Internal oscillator clock
  input wire logic serial_in, // Serial data in
  input wire logic latch_strobe, // Latch strobe pin
  input wire logic blank_pin, // Blank pin
  input wire logic [15:0] open_led_flag, // Open LED flags
  input wire logic [15:0] shorted_led_flag, // Shorted LED flags
  input wire logic [15:0] output_leak_flag, // Leak flags
  input wire logic thermal_error_flag, // Thermal error
  input wire logic thermal_warning_flag, // Thermal warning
  input wire logic ref_pin_short_flag, // Reference pin short
  output logic serial_out, // Serial output
  output lfc_pkg::lfc_word_t function_control_word, // Latch contents
  output logic [6:0] global_brightness_code, // Brightness scaling code
  output logic [15:0] sink_output_n_on, // Per-channel sink enables
  output logic short_threshold_select, // 1 = high threshold
  output logic [1:0] hidden_test_current_select, // Detection current code
  output logic hidden_detection_mode, // Detection current flowing
  output logic low_power_enable, // Power-save mode active
  output logic gate_pin_role_select // Blank pin role, 1 = enable
);
  import lfc_pkg::*;
  lfc_link_if lnk();
  lfc_word_t fc_q;
  logic [15:0] onoff_q;
  logic [2:0] fc_sync_q, on_sync_q;
  logic [1:0] blk_sync_q;
  logic st_tg_q, idm_tg_q;
  logic [15:0] st_word_q;
  logic [15:0] shift_hold_q;
  logic psave_q, force_off_q;
  logic [15:0] sink_q;
  logic hdm_q;
  logic [1:0] hdm_sync_q;
  logic idm_active;
  // Shift word is stable once the toggle arrives: the front end freezes shifting while the strobe stands
  wire fc_event = fc_sync_q[2] ^ fc_sync_q[1];
  wire on_event = on_sync_q[2] ^ on_sync_q[1];
  lfc_sls_e sls;
  assign sls = lfc_sls_e'(fc_q[`LFC_SLS_MSB:`LFC_SLS_LSB]);
  wire role_en = fc_q[`LFC_ROLE_BIT];
  wire force_off_d = role_en & blk_sync_q[1];
  wire all_off = (onoff_q == 16'h0000);
  wire psave_d = fc_q[`LFC_PSAVE_BIT] & all_off;
  logic [15:0] status_sel;
  always_comb begin
    case (sls)
      lfc_sls_open_thermal: status_sel = {open_led_flag[15:1], open_led_flag[0] | thermal_error_flag};
      lfc_sls_short_warn: status_sel = {shorted_led_flag[15:1], shorted_led_flag[0] | thermal_warning_flag};
      lfc_sls_leak_ref: status_sel = {output_leak_flag[15:1], output_leak_flag[0] | ref_pin_short_flag};
      default: status_sel = 16'h0000;
    endcase
  end
  lfc_shift_front u_front (
    .shift_clk(shift_clk),
    .reset_n(reset_n),
    .serial_in(serial_in),
    .latch_strobe(latch_strobe),
    .blank_pin(blank_pin),
    .role_out_en(role_en),
    .serial_out(serial_out),
    .lnk(lnk.front)
  );
  lfc_idm_timer u_idm (
    .osc_clk(osc_clk),
    .reset_n(reset_n),
    .start_toggle(idm_tg_q),
    .dur_sel(fc_q[`LFC_DUR_MSB:`LFC_DUR_LSB]),
    .sink_on(idm_active)
  );
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fc_sync_q <= 3'b000;
      on_sync_q <= 3'b000;
      blk_sync_q <= 2'b00;
      hdm_sync_q <= 2'b00;
    end else begin
      fc_sync_q <= {fc_sync_q[1:0], lnk.fc_toggle};
      on_sync_q <= {on_sync_q[1:0], lnk.onoff_toggle};
      blk_sync_q <= {blk_sync_q[0], blank_pin};
      hdm_sync_q <= {hdm_sync_q[0], idm_active};
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fc_q <= `LFC_RESET_WORD;
      onoff_q <= 16'h0000;
      shift_hold_q <= 16'h0000;
    end else begin
      shift_hold_q <= lnk.shift_word;
      if (fc_event) fc_q <= shift_hold_q;
      if (on_event) onoff_q <= shift_hold_q;
    end
  end
  // Status reload (select not 00) and hidden detection (current code not 00) start on an on/off update
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_tg_q <= 1'b0;
      st_word_q <= 16'h0000;
      idm_tg_q <= 1'b0;
    end else begin
      if (on_event && sls != lfc_sls_none) begin
        st_tg_q <= ~st_tg_q;
        st_word_q <= status_sel;
      end
      if (on_event && fc_q[`LFC_CUR_MSB:`LFC_CUR_LSB] != 2'b00) idm_tg_q <= ~idm_tg_q;
    end
  end
  assign lnk.status_word = st_word_q;
  assign lnk.status_toggle = st_tg_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      psave_q <= 1'b0;
      force_off_q <= 1'b0;
      sink_q <= 16'h0000;
      hdm_q <= 1'b0;
    end else begin
      psave_q <= psave_d;
      force_off_q <= force_off_d;
      sink_q <= force_off_d ? 16'h0000 : onoff_q;
      hdm_q <= hdm_sync_q[1];
    end
  end
  assign function_control_word = fc_q;
  assign global_brightness_code = fc_q[`LFC_BRIGHT_MSB:`LFC_BRIGHT_LSB];
  assign short_threshold_select = fc_q[`LFC_SHORT_BIT];
  assign hidden_test_current_select = fc_q[`LFC_CUR_MSB:`LFC_CUR_LSB];
  assign gate_pin_role_select = role_en;
  assign sink_output_n_on = sink_q;
  assign low_power_enable = psave_q;
  assign hidden_detection_mode = hdm_q;
  // Checks
  reset_word_a: assert property (@(posedge ref_clk) $rose(reset_n) |-> fc_q == 16'he67f)
    else $error("latch not at reset word");
  fc_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fc_event |=> fc_q == $past(shift_hold_q))
    else $error("function word not copied");
  psave_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (fc_q[15] && all_off) |=> low_power_enable)
    else $error("power save not entered");
  psave_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fc_q[15] |=> !low_power_enable)
    else $error("power save entered while disabled");
  force_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (force_off_d && !on_event) |=> sink_output_n_on == 16'h0000 ##0 $stable(onoff_q))
    else $error("outputs not forced off");
  no_status_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (on_event && sls == lfc_sls_none) |=> $stable(st_tg_q))
    else $error("status reloaded with select 00");
  status_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (on_event && sls != lfc_sls_none) |=> st_tg_q != $past(st_tg_q) ##0 st_word_q == $past(status_sel))
    else $error("status not reloaded");
  sequence idm_req_s;
    on_event && fc_q[12:11] != 2'b00;
  endsequence
  idm_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    idm_req_s |=> idm_tg_q != $past(idm_tg_q))
    else $error("hidden detection not started");
  brightness_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    global_brightness_code == fc_q[6:0] ##0 short_threshold_select == fc_q[10])
    else $error("field outputs wrong");
endmodule : lfc_core
`default_nettype wire

// ===== lfc_defines.svh
/*
  Offsets of fields, reset word and timing counts for the function control latch.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef LFC_DEFINES_SVH
`define LFC_DEFINES_SVH
`define LFC_WIDTH 16
`define LFC_RESET_WORD 16'he67f
`define LFC_BRIGHT_LSB 0
`define LFC_BRIGHT_MSB 6
`define LFC_SLS_LSB 7
`define LFC_SLS_MSB 8
`define LFC_ROLE_BIT 9
`define LFC_SHORT_BIT 10
`define LFC_CUR_LSB 11
`define LFC_CUR_MSB 12
`define LFC_DUR_LSB 13
`define LFC_DUR_MSB 14
`define LFC_PSAVE_BIT 15
`define LFC_SERIAL_OUT_TAP_LOW 7
`define LFC_DUR_CLKS0 8'd17
`define LFC_DUR_CLKS1 8'd33
`define LFC_DUR_CLKS2 8'd65
`define LFC_DUR_CLKS3 8'd129
`endif

// ===== lfc_pkg.sv
/*
  Types shared by the function control latch modules.
  Assumes lfc_defines.svh is available.
*/
`include "lfc_defines.svh"
package lfc_pkg;
  typedef logic [`LFC_WIDTH-1:0] lfc_word_t;
  typedef enum logic [1:0] {
    lfc_sls_none,
    lfc_sls_open_thermal,
    lfc_sls_short_warn,
    lfc_sls_leak_ref
  } lfc_sls_e;
  typedef enum logic {
    lfc_role_serial_out_sel,
    lfc_role_out_enable
  } lfc_role_e;
endpackage : lfc_pkg

// ===== lfc_link_if.sv
/*
  Carrier between the link-clock front end and the core latch.
  Assumes both ends run in their own clock domain; each end synchronizes the toggles it receives.
*/
`timescale 1ns/1ps
`default_nettype none
interface lfc_link_if;
  import lfc_pkg::*;
  logic [15:0] shift_word;
  logic fc_toggle;
  logic onoff_toggle;
  logic [15:0] status_word;
  logic status_toggle;
  modport front(output shift_word, output fc_toggle, output onoff_toggle, input status_word, input status_toggle);
  modport core(input shift_word, input fc_toggle, input onoff_toggle, output status_word, output status_toggle);
endinterface : lfc_link_if
`default_nettype wire

// ===== lfc_shift_front.sv
/*
  Serial shift register on the shift clock; decodes latch strobe edges.
  Assumes the host drives serial_in and latch_strobe in step with the shift clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lfc_shift_front (
  input wire logic shift_clk, // Link shift clock
  input wire logic reset_n, // Async reset, active low
  input wire logic serial_in, // Serial data from host
  input wire logic latch_strobe, // Latch strobe pin
  input wire logic blank_pin, // Blank pin, shift-clock synced here
  input wire logic role_out_en, // Stored role bit, level
  output logic serial_out, // Serial output pin
  lfc_link_if.front lnk // Toward the core
);
  import lfc_pkg::*;
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic lat_q, fc_tg_q, on_tg_q, st_seen_q;
  logic [1:0] st_sync_q, blk_sync_q, role_sync_q;
  wire st_event = st_sync_q[1] ^ st_seen_q;
  wire serial_out_low_sel = ~role_sync_q[1] & ~blk_sync_q[1];
  // Strobe is sampled on the falling edge so its rise can be seen against clock high or low
  logic lat_fq;
  always_ff @(negedge shift_clk or negedge reset_n) begin
    if (!reset_n) lat_fq <= 1'b0;
    else lat_fq <= latch_strobe;
  end
  // A rise during the high half is first seen by the falling-edge flop; one in the low half is not
  wire lat_rise_hi = lat_fq & ~lat_q;
  wire lat_rise_lo = latch_strobe & ~lat_fq & ~lat_q;
  // Shifting is frozen while the strobe stands so the strobed word stays put for the core
  wire shift_en = ~latch_strobe;
  assign sr_d = st_event ? lnk.status_word : (shift_en ? {sr_q[14:0], serial_in} : sr_q);
  always_ff @(posedge shift_clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= 16'h0000;
      lat_q <= 1'b0;
      fc_tg_q <= 1'b0;
      on_tg_q <= 1'b0;
      st_sync_q <= 2'b00;
      st_seen_q <= 1'b0;
      blk_sync_q <= 2'b00;
      role_sync_q <= 2'b00;
    end else begin
      sr_q <= sr_d;
      lat_q <= lat_fq | latch_strobe;
      st_sync_q <= {st_sync_q[0], lnk.status_toggle};
      st_seen_q <= st_sync_q[1];
      blk_sync_q <= {blk_sync_q[0], blank_pin};
      role_sync_q <= {role_sync_q[0], role_out_en};
      if (lat_rise_hi && !serial_out_low_sel) fc_tg_q <= ~fc_tg_q;
      if (lat_rise_lo && !lat_rise_hi) on_tg_q <= ~on_tg_q;
    end
  end
  assign lnk.shift_word = sr_q;
  assign lnk.fc_toggle = fc_tg_q;
  assign lnk.onoff_toggle = on_tg_q;
  always_ff @(posedge shift_clk or negedge reset_n) begin
    if (!reset_n) serial_out <= 1'b0;
    else serial_out <= serial_out_low_sel ? sr_d[`LFC_SERIAL_OUT_TAP_LOW] : sr_d[15];
  end
endmodule : lfc_shift_front
`default_nettype wire

// ===== lfc_idm_timer.sv
/*
  Hidden-detection on-time counter on the internal oscillator.
  Assumes start arrives as a toggle from another domain.
*/
`timescale 1ns/1ps
`default_nettype none
module lfc_idm_timer (
  input wire logic osc_clk, // Internal oscillator
  input wire logic reset_n, // Async reset, active low
  input wire logic start_toggle, // Start event, toggle from core
  input wire logic [1:0] dur_sel, // Duration code, quasi-static
  output logic sink_on // Detection current active
);
  logic [1:0] sync_q;
  logic seen_q;
  logic [7:0] cnt_q;
  logic [7:0] load_val;
  always_comb begin
    case (dur_sel)
      2'b00: load_val = `LFC_DUR_CLKS0;
      2'b01: load_val = `LFC_DUR_CLKS1;
      2'b10: load_val = `LFC_DUR_CLKS2;
      default: load_val = `LFC_DUR_CLKS3;
    endcase
  end
  wire start = sync_q[1] ^ seen_q;
  always_ff @(posedge osc_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 2'b00;
      seen_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      sync_q <= {sync_q[0], start_toggle};
      seen_q <= sync_q[1];
      if (start) cnt_q <= load_val;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
  assign sink_on = (cnt_q != 8'h00);
endmodule : lfc_idm_timer
`default_nettype wire

// ===== lfc_host_model.sv
/*
  Host side of the serial shift chain: shifts words in, strobes them, reads status out.
  Assumes the caller runs one task at a time; shift clock stands low outside frames.
*/
`timescale 1ns/1ps
`default_nettype none
module lfc_host_model (
  output logic shift_clk, // Shift clock, 30 ns when running
  output logic serial_in, // Serial data toward the device
  output logic latch_strobe, // Latch strobe
  input wire logic serial_out // Serial data from the device
);
  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
  end
  task automatic frame(input logic [15:0] w, input logic ctrl);
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #15 shift_clk = 1'b1;
      if (!(ctrl && i == 0)) #15 shift_clk = 1'b0;
    end
    // Strobe rises in the high half for control data, low half for on/off data
    #5 latch_strobe = 1'b1;
    if (ctrl) begin
      #10 shift_clk = 1'b0;
      #15 shift_clk = 1'b1;
    end else #10 shift_clk = 1'b1;
    #15 shift_clk = 1'b0;
    serial_in = ~serial_in;
    // Shift word held still while the core picks it up
    #150;
    repeat (3) begin
      #15 shift_clk = 1'b1;
      #15 shift_clk = 1'b0;
    end
    latch_strobe = 1'b0;
  endtask : frame
  task automatic read(output logic [15:0] cap);
    for (int i = 15; i >= 0; i--) begin
      cap[i] = serial_out;
      serial_in = ~serial_in;
      #15 shift_clk = 1'b1;
      #15 shift_clk = 1'b0;
    end
  endtask : read
endmodule : lfc_host_model
`default_nettype wire

// ===== testbench.sv
/*
  Self-checking bench for the function control latch against an integer model.
  Assumes lfc_core and lfc_host_model are compiled beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lfc_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, osc_clk = 1'b0, blank_pin = 1'b1;
  logic shift_clk, serial_in, latch_strobe, serial_out;
  logic [15:0] open_f = 16'h0, short_f = 16'h0, leak_f = 16'h0, cap, sinks;
  logic [6:0] bright;
  logic thr, hdm, lp, role;
  logic [1:0] cur;
  lfc_word_t fcw;
  integer errors = 0, num_checks = 0, seed = 49402, fc_m = 'he67f, onoff_m = 0, hd_cnt = 0, w;
  int durs[4] = '{17, 33, 65, 129};
  always #5 ref_clk = ~ref_clk;
  always #25 osc_clk = ~osc_clk;
  always @(posedge osc_clk) if (hdm === 1'b1) hd_cnt++;
  lfc_host_model host_inst (.shift_clk(shift_clk), .serial_in(serial_in), .latch_strobe(latch_strobe),
    .serial_out(serial_out));
  lfc_core lfc_core_inst (.ref_clk(ref_clk), .reset_n(reset_n), .shift_clk(shift_clk), .osc_clk(osc_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe), .blank_pin(blank_pin), .open_led_flag(open_f),
    .shorted_led_flag(short_f), .output_leak_flag(leak_f), .thermal_error_flag(1'b0),
    .thermal_warning_flag(1'b0), .ref_pin_short_flag(1'b0), .serial_out(serial_out),
    .function_control_word(fcw), .global_brightness_code(bright), .sink_output_n_on(sinks),
    .short_threshold_select(thr), .hidden_test_current_select(cur), .hidden_detection_mode(hdm),
    .low_power_enable(lp), .gate_pin_role_select(role));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic check_all;
    logic [15:0] f;
    f = fc_m[15:0];
    check("word", fcw, f);
    check("fields", {2'h0, role, thr, cur, bright, lp},
      {2'h0, f[9], f[10], f[12:11], f[6:0], f[15] && onoff_m == 0});
    check("sinks", sinks, (f[9] && blank_pin) ? 16'h0 : onoff_m[15:0]);
  endtask : check_all
  task automatic ctrl(input logic [15:0] v);
    host_inst.frame(v, 1'b1);
    // Writes in serial-select role with blank low are dropped
    if (fc_m[9] || blank_pin) fc_m = v;
    repeat (10) @(negedge ref_clk);
    check_all();
  endtask : ctrl
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    check_all();
    repeat (6) ctrl($random(seed));
    ctrl(16'h0000);
    @(negedge ref_clk) blank_pin = 1'b0;
    ctrl(16'hffff);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk) blank_pin = 1'b1;
      ctrl({i[0], i[1:0], (i == 0) ? 2'h1 : i[1:0], 1'b1, 1'b1, i[1:0], 7'($random(seed))});
      @(negedge ref_clk) begin
        open_f = $random(seed);
        short_f = $random(seed);
        leak_f = $random(seed);
        blank_pin = 1'b0;
      end
      w = (i >= 2) ? 0 : $random(seed);
      hd_cnt = 0;
      host_inst.frame(w[15:0], 1'b0);
      onoff_m = w[15:0];
      repeat (10) @(negedge ref_clk);
      check_all();
      if (i != 0) begin
        host_inst.read(cap);
        check("status", cap, (i == 1) ? open_f : (i == 2) ? short_f : leak_f);
      end
      repeat (800) @(negedge ref_clk);
      check("detect", hd_cnt[15:0], durs[i][15:0]);
      @(negedge ref_clk) blank_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      check_all();
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
